//--- rtl/cri_pkg.sv
// Constants and types for the operand inversion instruction unit
package cri_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned INSTR_W = 16;
    // Instruction word layout
    localparam int unsigned OPC_MSB = 15;
    localparam int unsigned OPC_LSB = 10;
    localparam logic [5:0] OPC_INVERT = 6'h07;
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned ACC_BIT = 8;
    localparam int unsigned FIELD_MSB = 7;
    localparam int unsigned FIELD_LSB = 0;
    // Access bank split and indexed window limit
    localparam logic [7:0] LOW_ACCESS_LAST = 8'h5F;
    localparam logic [3:0] LOW_ACCESS_BANK = 4'h0;
    localparam logic [3:0] HIGH_ACCESS_BANK = 4'hF;
    // Values after reset, and the sign bit of the result
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam int unsigned NEG_BIT = 7;

    typedef enum logic [1:0] {
        CRI_IDLE = 2'b00,
        CRI_READ = 2'b01,
        CRI_PROC = 2'b10,
        CRI_WRITE = 2'b11
    } cri_state_type;
endpackage

//--- rtl/cri_addr_if.sv
// Carrier between the instruction unit and its operand address resolver
interface cri_addr_if;
    logic [7:0] field;
    logic access_sel;
    logic [cri_pkg::BANK_W-1:0] bank_sel;
    logic ext_enable;
    logic [cri_pkg::ADDR_W-1:0] index_base;
    logic [cri_pkg::ADDR_W-1:0] addr;
    logic indexed;

    modport core (
        output field,
        output access_sel,
        output bank_sel,
        output ext_enable,
        output index_base,
        input addr,
        input indexed
    );
    modport resolver (
        input field,
        input access_sel,
        input bank_sel,
        input ext_enable,
        input index_base,
        output addr,
        output indexed
    );
endinterface

//--- rtl/cri_addr_resolve.sv
// Operand address resolver: access bank, banked or indexed literal offset
module cri_addr_resolve (
    cri_addr_if.resolver bus
);
    logic low_half;

    assign low_half = (bus.field <= cri_pkg::LOW_ACCESS_LAST);

    always_comb begin
        bus.indexed = 1'b0;
        if (bus.access_sel) begin
            bus.addr = {bus.bank_sel, bus.field};
        end else if (bus.ext_enable && low_half) begin
            // Offset is added to the index base, wrapping inside data space
            bus.addr = bus.index_base + {4'h0, bus.field};
            bus.indexed = 1'b1;
        end else if (low_half) begin
            bus.addr = {cri_pkg::LOW_ACCESS_BANK, bus.field};
        end else begin
            bus.addr = {cri_pkg::HIGH_ACCESS_BANK, bus.field};
        end
    end
endmodule

//--- rtl/cri_core.sv
// Operand inversion instruction unit: read, invert, write back, flags
module cri_core (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [cri_pkg::INSTR_W-1:0] instr_word,
    input wire logic [cri_pkg::BANK_W-1:0] bank_select_register,
    input wire logic ext_set_enable,
    input wire logic [cri_pkg::ADDR_W-1:0] index_base,
    input wire logic [cri_pkg::DATA_W-1:0] mem_rdata,
    output logic instr_ready,
    output logic [cri_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [cri_pkg::DATA_W-1:0] result_data,
    output logic w_we,
    output logic flag_we,
    output logic flag_neg,
    output logic flag_zero,
    output logic indexed_mode,
    output logic instr_done
);
    function automatic logic is_invert_op(input logic [cri_pkg::INSTR_W-1:0] word);
        return word[cri_pkg::OPC_MSB:cri_pkg::OPC_LSB] == cri_pkg::OPC_INVERT;
    endfunction

    cri_pkg::cri_state_type state_reg;
    cri_pkg::cri_state_type state_next;
    logic ready_reg;
    logic dest_reg;
    logic [cri_pkg::ADDR_W-1:0] addr_reg;
    logic indexed_reg;
    logic re_reg;
    logic mem_we_reg;
    logic w_we_reg;
    logic flag_we_reg;
    logic neg_reg;
    logic zero_reg;
    logic done_reg;
    logic [cri_pkg::DATA_W-1:0] result_reg;
    logic [cri_pkg::DATA_W-1:0] result_next;
    logic take;

    cri_addr_if addr_bus ();

    assign addr_bus.field = instr_word[cri_pkg::FIELD_MSB:cri_pkg::FIELD_LSB];
    assign addr_bus.access_sel = instr_word[cri_pkg::ACC_BIT];
    assign addr_bus.bank_sel = bank_select_register;
    assign addr_bus.ext_enable = ext_set_enable;
    assign addr_bus.index_base = index_base;

    cri_addr_resolve u_resolve (
        .bus(addr_bus.resolver)
    );

    // Other opcodes are left to the rest of the decoder and simply ignored
    assign take = ready_reg && instr_valid && is_invert_op(instr_word);
    assign result_next = ~mem_rdata;

    // Fixed walk: read, process, write; the accumulator case takes no shortcut
    always_comb begin
        case (state_reg)
            cri_pkg::CRI_IDLE: state_next = take ? cri_pkg::CRI_READ : cri_pkg::CRI_IDLE;
            cri_pkg::CRI_READ: state_next = cri_pkg::CRI_PROC;
            cri_pkg::CRI_PROC: state_next = cri_pkg::CRI_WRITE;
            cri_pkg::CRI_WRITE: state_next = cri_pkg::CRI_IDLE;
            default: state_next = cri_pkg::CRI_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= cri_pkg::CRI_IDLE;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == cri_pkg::CRI_IDLE);
        end
    end

    // Address and destination held for the whole instruction
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addr_reg <= cri_pkg::ADDR_RESET;
            dest_reg <= 1'b0;
            indexed_reg <= 1'b0;
        end else if (take) begin
            addr_reg <= addr_bus.addr;
            dest_reg <= instr_word[cri_pkg::DEST_BIT];
            indexed_reg <= addr_bus.indexed;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            re_reg <= 1'b0;
        end else begin
            re_reg <= take;
        end
    end

    // Memory answers one cycle after the read strobe; sampled in the process step
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_reg <= cri_pkg::DATA_RESET;
            mem_we_reg <= 1'b0;
            w_we_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (state_reg == cri_pkg::CRI_PROC) begin
            result_reg <= result_next;
            mem_we_reg <= dest_reg;
            w_we_reg <= !dest_reg;
            done_reg <= 1'b1;
        end else begin
            mem_we_reg <= 1'b0;
            w_we_reg <= 1'b0;
            done_reg <= 1'b0;
        end
    end

    // Only N and Z are produced; the flag owner keeps the others
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_we_reg <= 1'b0;
            neg_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else if (state_reg == cri_pkg::CRI_PROC) begin
            flag_we_reg <= 1'b1;
            neg_reg <= result_next[cri_pkg::NEG_BIT];
            zero_reg <= (result_next == cri_pkg::DATA_RESET);
        end else begin
            flag_we_reg <= 1'b0;
        end
    end

    assign instr_ready = ready_reg;
    assign mem_addr = addr_reg;
    assign mem_re = re_reg;
    assign mem_we = mem_we_reg;
    assign result_data = result_reg;
    assign w_we = w_we_reg;
    assign flag_we = flag_we_reg;
    assign flag_neg = neg_reg;
    assign flag_zero = zero_reg;
    assign indexed_mode = indexed_reg;
    assign instr_done = done_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_invert_result: assert property (
        state_reg == cri_pkg::CRI_PROC |=> result_data == ~$past(mem_rdata))
        else $error("result is not the inverted operand");
    a_accum_dest: assert property (
        take && !instr_word[cri_pkg::DEST_BIT] |-> ##3 (w_we && !mem_we))
        else $error("accumulator destination not honoured");
    a_mem_dest: assert property (
        take && instr_word[cri_pkg::DEST_BIT] |-> ##3 (mem_we && !w_we
            && mem_addr == $past(mem_addr, 2)))
        else $error("write back missing or at wrong address");
    a_access_bank: assert property (
        take && !instr_word[cri_pkg::ACC_BIT]
            && !(ext_set_enable && instr_word[7:0] <= cri_pkg::LOW_ACCESS_LAST)
        |=> mem_addr == {($past(instr_word[7:0]) <= cri_pkg::LOW_ACCESS_LAST)
            ? cri_pkg::LOW_ACCESS_BANK : cri_pkg::HIGH_ACCESS_BANK,
            $past(instr_word[7:0])})
        else $error("access bank address wrong");
    a_bank_select: assert property (
        take && instr_word[cri_pkg::ACC_BIT]
        |=> mem_addr == {$past(bank_select_register), $past(instr_word[7:0])})
        else $error("banked address wrong");
    a_indexed_offset: assert property (
        take && !instr_word[cri_pkg::ACC_BIT] && ext_set_enable
            && instr_word[7:0] <= cri_pkg::LOW_ACCESS_LAST
        |=> indexed_mode && mem_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])})
        else $error("indexed literal offset address wrong");
    a_flag_update: assert property (
        flag_we |-> (flag_neg == result_data[cri_pkg::NEG_BIT])
            && (flag_zero == (result_data == cri_pkg::DATA_RESET)) && instr_done)
        else $error("flags disagree with result");
    a_read_then_done: assert property (
        mem_re |-> !instr_ready ##1 !mem_we[*1] ##1 (instr_done && flag_we) ##1 instr_ready)
        else $error("instruction sequence timing wrong");
    // Held outputs let the register file and flag owner sample late
    a_addr_held: assert property (
        !take |=> $stable(mem_addr) && $stable(indexed_mode))
        else $error("operand address moved without a new instruction");
    a_result_held: assert property (
        !instr_done |-> $stable(result_data))
        else $error("result changed outside the write step");
    a_flags_held: assert property (
        !flag_we |-> $stable(flag_neg) && $stable(flag_zero))
        else $error("flags changed without an update strobe");
    a_zero_not_neg: assert property (
        flag_we && flag_zero |-> !flag_neg)
        else $error("zero result reported as negative");
    a_single_dest: assert property (
        !(w_we && mem_we))
        else $error("both destinations written at once");
    a_accum_keeps_mem: assert property (
        state_reg == cri_pkg::CRI_PROC && !dest_reg |=> w_we && !mem_we)
        else $error("memory written for accumulator destination");
    a_refused_word: assert property (
        instr_valid && instr_ready && !is_invert_op(instr_word) |=> !mem_re && !instr_done)
        else $error("foreign opcode started an instruction");
    a_done_pulse: assert property (
        instr_done |=> !instr_done)
        else $error("completion pulse longer than one cycle");
    a_busy_span: assert property (
        take |=> !instr_ready [*3] ##1 instr_ready)
        else $error("busy span is not three cycles");

    c_to_accum: cover property (take && !instr_word[cri_pkg::DEST_BIT] ##3 w_we);
    c_write_back: cover property (take && instr_word[cri_pkg::DEST_BIT] ##3 mem_we);
    c_indexed: cover property (take ##1 indexed_mode);
    c_zero_result: cover property (flag_we && flag_zero);
    c_banked: cover property (take && instr_word[cri_pkg::ACC_BIT] ##1 mem_re);
endmodule

//--- verification/cri_mem_model.sv
// Data memory partner model: read answered one cycle after the strobe
module cri_mem_model (
    input wire logic mclk,
    input wire logic [cri_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [cri_pkg::DATA_W-1:0] wdata,
    output logic [cri_pkg::DATA_W-1:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [cri_pkg::DATA_W-1:0] store [4096];
    initial rdata = 8'h00;
    // Outside the answer cycle the line toggles so stale data never looks valid
    always @(posedge mclk) begin
        if (mem_re) begin
            rdata <= store[mem_addr];
        end else begin
            rdata <= ~rdata;
        end
        if (mem_we) begin
            store[mem_addr] <= wdata;
        end
    end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the operand inversion instruction unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_en = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] bank_sel = 4'h0;
    logic [11:0] idx_base = 12'h000, mem_addr;
    logic [7:0] mem_rdata, result_data;
    logic instr_ready, mem_re, mem_we, w_we, flag_we, flag_neg, flag_zero;
    logic indexed_mode, instr_done;
    int err_total = 0, n_checks = 0, cyc = 0;
    cri_core dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .bank_select_register(bank_sel), .ext_set_enable(ext_en),
        .index_base(idx_base), .mem_rdata(mem_rdata), .instr_ready(instr_ready),
        .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .result_data(result_data),
        .w_we(w_we), .flag_we(flag_we), .flag_neg(flag_neg), .flag_zero(flag_zero),
        .indexed_mode(indexed_mode), .instr_done(instr_done));
    cri_mem_model mem (.mclk(mclk), .mem_addr(mem_addr), .mem_re(mem_re),
        .mem_we(mem_we), .wdata(result_data), .rdata(mem_rdata));
    initial forever #5 mclk = ~mclk;
    task automatic test_done();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    // One instruction from offer to write-back, judged against the expected address
    task automatic run(input logic d, input logic a, input logic [7:0] f,
        input logic [3:0] b, input logic x, input logic [11:0] base, input logic [7:0] v);
        logic ix;
        logic [11:0] ea;
        ix = x && !a && f <= 8'h5F;
        ea = a ? {b, f} : ix ? base + {4'h0, f} : {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
        mem.store[ea] = v;
        @(posedge mclk);
        instr_word <= {6'h07, d, a, f};
        bank_sel <= b;
        ext_en <= x;
        idx_base <= base;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk({mem_re, instr_ready}, 2'b10);
        repeat (2) @(posedge mclk);
        #1;
        chk(instr_done, 1'b1);
        chk(result_data, {4'h0, ~v});
        chk(mem_addr, ea);
        chk(indexed_mode, ix);
        chk({flag_we, flag_neg, flag_zero}, {1'b1, ~v[7], v == 8'hFF});
        chk({w_we, mem_we}, {!d, d});
        @(posedge mclk);
        #1;
        chk(mem.store[ea], {4'h0, d ? ~v : v});
        chk(instr_ready, 1'b1);
    endtask
    task automatic t_access_low();
        run(1'b0, 1'b0, 8'h13, 4'h3, 1'b0, 12'h000, 8'h13);
    endtask
    task automatic t_access_high();
        run(1'b1, 1'b0, 8'h60, 4'h3, 1'b1, 12'h100, 8'h80);
    endtask
    task automatic t_banked();
        run(1'b1, 1'b1, 8'h05, 4'h5, 1'b1, 12'h100, 8'hFF);
        run(1'b0, 1'b1, 8'hFF, 4'hF, 1'b0, 12'h000, 8'h5A);
    endtask
    task automatic t_indexed();
        run(1'b0, 1'b0, 8'h5F, 4'h5, 1'b1, 12'hFF0, 8'h00);
        run(1'b1, 1'b0, 8'h00, 4'h2, 1'b1, 12'h3A0, 8'hC3);
    endtask
    // Other opcodes must pass without any strobe
    task automatic t_refused();
        @(posedge mclk);
        instr_word <= {6'h08, 2'b11, 8'h20};
        instr_valid <= 1'b1;
        repeat (5) begin
            @(posedge mclk);
            #1;
            chk({instr_done, mem_re, mem_we, w_we, flag_we, instr_ready}, 6'h01);
        end
        @(posedge mclk);
        instr_valid <= 1'b0;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        t_access_low();
        t_access_high();
        t_banked();
        t_indexed();
        t_refused();
        test_done();
    end
endmodule
